/* sadc_pkg.sv */
// Shared constants and types for the successive-approximation converter control block.
`default_nettype none

package sadc_pkg;

	// ****************************************************************
	// Register map: printed offsets are word indexes on the bus.
	// ****************************************************************
	localparam int         ADDR_W     = 10;
	localparam logic [7:0] IDX_RES_HI = 8'hfa;
	localparam logic [7:0] IDX_RES_LO = 8'hfb;
	localparam logic [7:0] IDX_CTRL   = 8'hfc;

	// ****************************************************************
	// Control register field layout.
	// ****************************************************************
	localparam int CTL_START   = 0;
	localparam int CTL_SPD_LSB = 1;
	localparam int CTL_SPD_W   = 2;
	localparam int CTL_EOC     = 3;
	localparam int CTL_CH_LSB  = 4;
	localparam int CTL_CH_W    = 4;

	// ****************************************************************
	// Result layout and conversion timing in conversion clocks.
	// ****************************************************************
	localparam int                  RES_BITS     = 10;
	localparam int                  RES_HI_W     = 8;
	localparam int                  RES_LO_W     = 2;
	localparam logic [RES_BITS-1:0] SAR_MID      = 10'h200;
	localparam int                  SETUP_CLKS   = 10;
	localparam int                  CLKS_PER_BIT = 4;
	localparam int                  CONV_CLKS    = SETUP_CLKS + CLKS_PER_BIT * RES_BITS;
	localparam logic [3:0]          SETUP_LAST   = 4'(SETUP_CLKS - 1);
	localparam logic [1:0]          PHASE_LAST   = 2'(CLKS_PER_BIT - 1);
	localparam logic [3:0]          BIT_TOP      = 4'(RES_BITS - 1);

	// ****************************************************************
	// Conversion clock division selected by the speed field.
	// ****************************************************************
	typedef enum logic [1:0] {SPD_DIV16, SPD_DIV8, SPD_DIV4, SPD_DIV1} sadc_spd_t;
	localparam logic [3:0] LIM_DIV16 = 4'hf;
	localparam logic [3:0] LIM_DIV8  = 4'h7;
	localparam logic [3:0] LIM_DIV4  = 4'h3;
	localparam logic [3:0] LIM_DIV1  = 4'h0;

	// Sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_BITS} sadc_st_t;

endpackage : sadc_pkg

`default_nettype wire

/* sadc_conv_if.sv */
// Bundle between the register front end, the clock divider and the sequencer.
`default_nettype none

interface sadc_conv_if;
	logic                           tick;
	logic                           start;
	logic [1:0]                     speed;
	logic                           busy;
	logic                           done;
	logic                           cmp;
	logic [sadc_pkg::RES_BITS-1:0]  code;

	modport top (output start, speed, cmp, input busy, done, code);
	modport div (input speed, busy, output tick);
	modport sar (input tick, start, cmp, output busy, done, code);
endinterface : sadc_conv_if

`default_nettype wire

/* sadc_clkdiv.sv */
// Conversion clock enable generator dividing the main clock by the selected speed.
`default_nettype none

module sadc_clkdiv #(
	parameter int DIV_W = 4
) (
	input wire logic  core_clk,
	input wire logic  reset,
	sadc_conv_if.div  cv
);

	// Every division limit must fit the counter.
	if (DIV_W < 4) begin : g_chk
		$error("sadc_clkdiv: DIV_W too small for the division limits");
	end

	logic [DIV_W-1:0] cnt_ff;
	logic             tick_ff;
	logic [DIV_W-1:0] lim;

	// ****************************************************************
	// Division select.
	// ****************************************************************
	// speed selects division.
	assign lim = (cv.speed == sadc_pkg::SPD_DIV16) ? DIV_W'(sadc_pkg::LIM_DIV16) :
	             (cv.speed == sadc_pkg::SPD_DIV8)  ? DIV_W'(sadc_pkg::LIM_DIV8)  :
	             (cv.speed == sadc_pkg::SPD_DIV4)  ? DIV_W'(sadc_pkg::LIM_DIV4)  :
	                                                 DIV_W'(sadc_pkg::LIM_DIV1);
	assign cv.tick = tick_ff;

	// The counter restarts while idle so each conversion begins on a clean period.
	always_ff @(posedge core_clk) begin
		if (reset || !cv.busy) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (cnt_ff == lim) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + DIV_W'(1);
			tick_ff <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_div8_gap;
		(cv.tick && cv.speed == sadc_pkg::SPD_DIV8) |=> (!cv.tick)[*7] ##1 (cv.tick || !cv.busy);
	endproperty
	a_div8_gap: assert property (p_div8_gap) else $error("divide-by-8 tick spacing wrong");

endmodule : sadc_clkdiv

`default_nettype wire

/* sadc_sar.sv */
// Successive-approximation sequencer: set-up wait then one decision per result bit.
`default_nettype none

module sadc_sar (
	input wire logic  core_clk,
	input wire logic  reset,
	sadc_conv_if.sar  cv
);

	localparam int W = sadc_pkg::RES_BITS;

	sadc_pkg::sadc_st_t state_ff;
	logic [3:0]         cnt_ff;
	logic [1:0]         phase_ff;
	logic [3:0]         bit_ff;
	logic [W-1:0]       code_ff;
	logic               done_ff;
	logic [5:0]         len_ff;

	// Keep or drop the trial bit, then raise the next lower trial bit.
	function automatic logic [W-1:0] sar_step(input logic [W-1:0] c, input logic [3:0] b, input logic keep);
		logic [W-1:0] r;
		r = c;
		if (!keep) begin
			r[b] = 1'b0;
		end
		if (b != 4'h0) begin
			r[b - 4'h1] = 1'b1;
		end
		return r;
	endfunction : sar_step

	assign cv.busy = (state_ff != sadc_pkg::ST_IDLE);
	assign cv.done = done_ff;
	assign cv.code = code_ff;

	// ****************************************************************
	// Sequencer.
	// ****************************************************************
	// ten set-up then four per bit.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= sadc_pkg::ST_IDLE;
			cnt_ff   <= 4'h0;
			phase_ff <= 2'h0;
			bit_ff   <= 4'h0;
			code_ff  <= '0;
			done_ff  <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				sadc_pkg::ST_IDLE: begin
					if (cv.start) begin
						code_ff  <= sadc_pkg::SAR_MID;
						cnt_ff   <= 4'h0;
						state_ff <= sadc_pkg::ST_SETUP;
					end
				end
				sadc_pkg::ST_SETUP: begin
					if (cv.tick && cnt_ff == sadc_pkg::SETUP_LAST) begin
						phase_ff <= 2'h0;
						bit_ff   <= sadc_pkg::BIT_TOP;
						state_ff <= sadc_pkg::ST_BITS;
					end else if (cv.tick) begin
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				sadc_pkg::ST_BITS: begin
					if (cv.tick && phase_ff == sadc_pkg::PHASE_LAST) begin
						phase_ff <= 2'h0;
						code_ff <= sar_step(code_ff, bit_ff, cv.cmp);
						if (bit_ff == 4'h0) begin
							done_ff  <= 1'b1;
							state_ff <= sadc_pkg::ST_IDLE;
						end else begin
							bit_ff <= bit_ff - 4'h1;
						end
					end else if (cv.tick) begin
						phase_ff <= phase_ff + 2'h1;
					end
				end
				default: begin
					state_ff <= sadc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Tick counter seen only by the length check below.
	always_ff @(posedge core_clk) begin
		if (reset || (cv.start && !cv.busy)) begin
			len_ff <= 6'h0;
		end else if (cv.busy && cv.tick) begin
			len_ff <= len_ff + 6'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_mid;
		(cv.start && !cv.busy) |=> (cv.code == sadc_pkg::SAR_MID) && cv.busy;
	endproperty
	a_mid: assert property (p_mid) else $error("conversion did not start at mid-scale");

	property p_len;
		cv.done |-> (len_ff == 6'(sadc_pkg::CONV_CLKS));
	endproperty
	a_len: assert property (p_len) else $error("conversion length is not 50 clocks");

	property p_dec;
		(state_ff == sadc_pkg::ST_BITS && cv.tick && phase_ff == sadc_pkg::PHASE_LAST)
			|=> (cv.code[$past(bit_ff)] == $past(cv.cmp));
	endproperty
	a_dec: assert property (p_dec) else $error("trial bit not decided by comparator");

endmodule : sadc_sar

`default_nettype wire

/* sadc_top.sv */
// Converter control block: register front end on the bus and conversion sequencing.
//
// Summary of operation
// - Writing one to control bit 0 starts a conversion on the selected channel.
// - Control bits 7 to 4 pick one of sixteen analog inputs and may change between conversions.
// - The control register is read and written by software at index 0xfc.
// - Each conversion loads the approximation register with 0x200 and updates it every bit step.
// - Only one channel is converted at a time, to full ten bits.
// - Finishing a conversion sets the done flag in control bit 3 by hardware.
// - The finished result lands in the result registers and the block then idles until started.
// - A new conversion overwrites the result, so software reads both halves before restarting.
// - A conversion takes ten set-up clocks plus four clocks per bit, fifty conversion clocks.
// - Control bits 2 and 1 choose the main-clock division used as conversion clock.
// - Reset clears the start bit so nothing converts until software asks.
// - The high result register at index 0xfa is read-only and holds eight result bits.
// - The low result register at index 0xfb is read-only with two result bits in bits 1 and 0.
// - The high register carries the eight upper result bits, the low one the two lower bits.
//
// The Avalon-MM register port was chosen for this implementation.
`default_nettype none

module sadc_top (
	input  wire logic                              core_clk,
	input  wire logic                              reset,
	input  wire logic [sadc_pkg::ADDR_W-1:0]       avs_address,
	input  wire logic                              avs_read,
	input  wire logic                              avs_write,
	input  wire logic [31:0]                       avs_writedata,
	input  wire logic [3:0]                        avs_byteenable,
	output logic      [31:0]                       avs_readdata,
	output logic                                   avs_waitrequest,
	input  wire logic                              cmp_above,
	output logic      [sadc_pkg::RES_BITS-1:0]     dac_code,
	output logic      [sadc_pkg::CTL_CH_W-1:0]     chan_sel,
	output logic                                   conv_busy
);

	localparam int RW = sadc_pkg::RES_BITS;
	localparam int CW = sadc_pkg::CTL_CH_W;
	localparam int SW = sadc_pkg::CTL_SPD_W;

	// ****************************************************************
	// Storage.
	// ****************************************************************
	logic [31:0]   readdata_ff;
	logic          wait_ff;
	logic          start_ff;
	logic          start_pl_ff;
	logic          eoc_ff;
	logic [CW-1:0] ch_ff;
	logic [SW-1:0] spd_ff;
	logic [CW-1:0] chan_sel_ff;
	logic [SW-1:0] spd_run_ff;
	logic [RW-1:0] res_ff;
	logic          cmp_meta_ff;
	logic          cmp_sync_ff;

	sadc_conv_if u_if ();

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	// Word index to byte address match; low address bits must be zero.
	function automatic logic addr_hit(input logic [sadc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {idx, 2'b00};
	endfunction : addr_hit

	wire           req       = avs_read || avs_write;
	wire           hit_ctrl  = addr_hit(avs_address, sadc_pkg::IDX_CTRL);
	wire           hit_hi    = addr_hit(avs_address, sadc_pkg::IDX_RES_HI);
	wire           hit_lo    = addr_hit(avs_address, sadc_pkg::IDX_RES_LO);
	wire           wr_acc    = avs_write && !wait_ff;
	wire           rd_ld     = avs_read && wait_ff;
	wire           ctrl_wr   = wr_acc && hit_ctrl && avs_byteenable[0];
	wire [CW-1:0]  wr_ch     = avs_writedata[sadc_pkg::CTL_CH_LSB +: CW];
	wire [SW-1:0]  wr_spd    = avs_writedata[sadc_pkg::CTL_SPD_LSB +: SW];

	// start on bit write.
	// A start while busy is dropped: the sequencer serves one channel at a time.
	wire           start_acc = ctrl_wr && avs_writedata[sadc_pkg::CTL_START] && !start_ff;

	// ****************************************************************
	// Read data selection.
	// ****************************************************************
	// control readback.
	wire [7:0]     ctrl_rd   = {ch_ff, eoc_ff, spd_ff, start_ff};
	wire [7:0]     hi_rd     = res_ff[RW-1 -: sadc_pkg::RES_HI_W];
	wire [7:0]     lo_rd     = {6'h00, res_ff[sadc_pkg::RES_LO_W-1:0]};
	// Unmapped addresses read as zero and ignore writes.
	wire [31:0]    rd_mux    = hit_ctrl ? {24'h000000, ctrl_rd} :
	                           hit_hi   ? {24'h000000, hi_rd}   :
	                           hit_lo   ? {24'h000000, lo_rd}   : 32'h00000000;

	// ****************************************************************
	// Bus handshake.
	// ****************************************************************
	// One wait cycle per access keeps the read data registered before it is sampled.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= !(req && wait_ff);
		end
	end

	// Read data is captured as the wait is lowered and held until the next read.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			readdata_ff <= 32'h00000000;
		end else if (rd_ld) begin
			readdata_ff <= rd_mux;
		end
	end

	// ****************************************************************
	// Control register.
	// ****************************************************************
	// channel field written.
	// speed field written.
	// Both fields may be written at any time; a start uses the fields of its own write, not the stored ones.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ch_ff  <= '0;
			spd_ff <= '0;
		end else if (ctrl_wr) begin
			ch_ff  <= wr_ch;
			spd_ff <= wr_spd;
		end
	end

	// idle after done.
	// The start bit reads one for the whole conversion and clears with the done pulse.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			start_ff    <= 1'b0;
			start_pl_ff <= 1'b0;
		end else begin
			start_pl_ff <= start_acc;
			if (start_acc) begin
				start_ff <= 1'b1;
			end else if (u_if.done) begin
				start_ff <= 1'b0;
			end
		end
	end

	// start clears flag.
	// Set is tested first so a finishing conversion is never lost.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			eoc_ff <= 1'b0;
		end else if (u_if.done) begin
			eoc_ff <= 1'b1;
		end else if (start_acc) begin
			eoc_ff <= 1'b0;
		end
	end

	// latch channel per conversion.
	// Channel and speed are frozen at start so a rewrite cannot disturb a running conversion.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			chan_sel_ff <= '0;
			spd_run_ff  <= '0;
		end else if (start_acc) begin
			chan_sel_ff <= wr_ch;
			spd_run_ff  <= wr_spd;
		end
	end

	// ****************************************************************
	// Result registers.
	// ****************************************************************
	// store result.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			res_ff <= '0;
		end else if (u_if.done) begin
			res_ff <= u_if.code;
		end
	end

	// ****************************************************************
	// Comparator input synchroniser.
	// ****************************************************************
	// The comparator pin is asynchronous; only the second stage is used.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end else begin
			cmp_meta_ff <= cmp_above;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// ****************************************************************
	// Sequencer and divider.
	// ****************************************************************
	assign u_if.start = start_pl_ff;
	assign u_if.speed = spd_run_ff;
	assign u_if.cmp   = cmp_sync_ff;

	sadc_clkdiv #(
		.DIV_W (4)
	) u_div (
		.core_clk (core_clk),
		.reset    (reset),
		.cv       (u_if.div)
	);

	sadc_sar u_sar (
		.core_clk (core_clk),
		.reset    (reset),
		.cv       (u_if.sar)
	);

	// Outputs.
	assign avs_readdata    = readdata_ff;
	assign avs_waitrequest = wait_ff;
	assign dac_code        = u_if.code;
	assign chan_sel        = chan_sel_ff;
	assign conv_busy       = start_ff;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_start;
		start_acc |=> start_ff && u_if.start ##1 u_if.busy;
	endproperty
	a_start: assert property (p_start) else $error("start write did not launch a conversion");

	property p_chan;
		start_acc |=> (chan_sel_ff == $past(wr_ch));
	endproperty
	a_chan: assert property (p_chan) else $error("selected channel not routed");

	property p_rd_ctrl;
		(rd_ld && hit_ctrl) |=> (avs_readdata[7:0] == $past(ctrl_rd)) && !avs_waitrequest;
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");

	property p_hold;
		(start_ff && $past(start_ff)) |-> $stable(chan_sel_ff) && $stable(spd_run_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("channel changed during conversion");

	property p_eoc;
		u_if.done |=> eoc_ff && !start_ff;
	endproperty
	a_eoc: assert property (p_eoc) else $error("done flag not set at completion");

	property p_res;
		u_if.done |=> (res_ff == $past(u_if.code)) ##1 !u_if.busy;
	endproperty
	a_res: assert property (p_res) else $error("result not stored at completion");

	property p_rst;
		disable iff (1'b0) reset |=> !start_ff && !eoc_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("reset left start bit set");

	property p_ro;
		(wr_acc && (hit_hi || hit_lo) && !u_if.done) |=> $stable(res_ff);
	endproperty
	a_ro: assert property (p_ro) else $error("result register changed by a write");

	property p_rd_lo;
		(rd_ld && hit_lo) |=> (avs_readdata[31:2] == 30'h00000000)
			&& (avs_readdata[1:0] == $past(res_ff[1:0]));
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("low result readback wrong");

	property p_rd_hi;
		(rd_ld && hit_hi) |=> (avs_readdata[7:0] == $past(res_ff[RW-1 -: 8]));
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("high result readback wrong");

	property p_clr;
		start_acc |=> !eoc_ff;
	endproperty
	a_clr: assert property (p_clr) else $error("done flag not cleared by start");

	property p_spd;
		start_acc |=> (u_if.speed == $past(wr_spd));
	endproperty
	a_spd: assert property (p_spd) else $error("speed field not routed to the divider");

	property p_bus;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest stayed low past one cycle");

endmodule : sadc_top

`default_nettype wire

/* sadc_cmp_model.sv */
// Behavioural comparator and reference ladder standing at the converter's analog side.
`default_nettype none

module sadc_cmp_model (
	input  wire logic [sadc_pkg::RES_BITS-1:0] level,
	input  wire logic [sadc_pkg::RES_BITS-1:0] dac_code,
	output logic                               cmp_above
);
	// ****************************************************************
	// Comparison against the trial level
	// ****************************************************************
	// The input is held steady during a conversion, because there is no sample-and-hold.
	// An equal level counts as above, so a perfect conversion returns the level itself.
	// keep when above
	assign cmp_above = (level >= dac_code);
endmodule : sadc_cmp_model

`default_nettype wire

/* sadc_top_tb.sv */
// Self-checking bench for the converter control block with a behavioural comparator.
`default_nettype none

module sadc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals and constants
	// ****************************************************************
	localparam logic [9:0] A_CTRL = {sadc_pkg::IDX_CTRL, 2'b00};
	localparam logic [9:0] A_HI   = {sadc_pkg::IDX_RES_HI, 2'b00};
	localparam logic [9:0] A_LO   = {sadc_pkg::IDX_RES_LO, 2'b00};
	localparam int         LIMIT  = 20000;
	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cmp_above;
	logic [9:0]  dac_code;
	logic [3:0]  chan_sel;
	logic        conv_busy;
	logic [9:0]  level = 10'h000;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc_count = 0;

	// The clock toggles every 5 ns, half of its 10 ns period.
	always #5 core_clk = ~core_clk;

	sadc_top dut_u (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_above(cmp_above),
		.dac_code(dac_code), .chan_sel(chan_sel), .conv_busy(conv_busy));

	sadc_cmp_model cmp_u (.level(level), .dac_code(dac_code), .cmp_above(cmp_above));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d.", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// A request stands until waitrequest is sampled low; the wait is cut only by the bench timeout.
	task automatic bus_cycle(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		forever begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus_cycle

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus_cycle(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [7:0] q);
		bus_cycle(1'b0, a, 8'h00, q);
	endtask : rd

	task automatic wait_idle();
		while (conv_busy !== 1'b0) @(posedge core_clk);
	endtask : wait_idle

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_and_fields();
		logic [7:0] q;
		rd(A_CTRL, q);
		chk(q, 8'h00, "ctrl after reset");
		chk(conv_busy, 1'b0, "idle after reset");
		wr(A_CTRL, 8'h86);
		rd(A_CTRL, q);
		chk(q, 8'h86, "ctrl read back");
		// A control write without byte lane 0 must leave the register and the sequencer alone.
		avs_byteenable <= 4'h0;
		wr(A_CTRL, 8'h51);
		avs_byteenable <= 4'h1;
		rd(A_CTRL, q);
		chk(q, 8'h86, "write without byte lane 0 ignored");
		chk(conv_busy, 1'b0, "no start without bit 0");
	endtask : t_reset_and_fields

	// One full conversion at a given speed; the busy time scales with the division.
	task automatic t_conv(input logic [1:0] spd, input logic [3:0] ch, input logic [9:0] lv);
		logic [7:0] q;
		int         div;
		time        t0;
		div   = (spd == 2'd0) ? 16 : (spd == 2'd1) ? 8 : (spd == 2'd2) ? 4 : 1;
		level <= lv;
		wr(A_CTRL, {ch, 1'b0, spd, 1'b1});
		t0 = $time;
		@(posedge core_clk);
		chk(conv_busy, 1'b1, "busy after start");
		chk(chan_sel, ch, "channel routed");
		rd(A_CTRL, q);
		chk(q[3:0], {1'b0, spd, 1'b1}, "done cleared, start set");
		chk(dac_code, 10'h200, "mid-scale trial");
		wait_idle();
		chk(($time - t0) / 10 >= 50 * div && ($time - t0) / 10 <= 50 * div + 4, 1'b1, "length");
		rd(A_CTRL, q);
		chk(q[3:0], {1'b1, spd, 1'b0}, "done set, start clear");
		rd(A_HI, q);
		chk(q, lv[9:2], "upper eight bits");
		rd(A_LO, q);
		chk(q[1:0], lv[1:0], "lower two bits");
	endtask : t_conv

	// A start while busy is refused; the channel in use does not move.
	task automatic t_refused_start();
		logic [7:0] q;
		// Low result bits are zero here so that a stray write of ones would show.
		level <= 10'h1c4;
		wr(A_CTRL, 8'h47);
		repeat (20) @(posedge core_clk);
		wr(A_CTRL, 8'h77);
		chk(chan_sel, 4'h4, "one channel at a time");
		wait_idle();
		repeat (3) @(posedge core_clk);
		chk(conv_busy, 1'b0, "second start ignored, back to idle");
		rd(A_CTRL, q);
		chk(q, 8'h7e, "channel stored while busy for next start");
		rd(A_HI, q);
		chk(q, 8'h71, "result of running conversion");
		wr(A_HI, 8'hff);
		wr(A_LO, 8'hff);
		rd(A_HI, q);
		chk(q, 8'h71, "high result read-only");
		rd(A_LO, q);
		chk(q[1:0], 2'b00, "low result read-only");
		rd(10'h000, q);
		chk(q, 8'h00, "unmapped reads zero");
	endtask : t_refused_start

	// ****************************************************************
	// Main sequence and timeout
	// ****************************************************************
	always @(posedge core_clk) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == LIMIT) begin
			bad_count++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_reset_and_fields();
		t_conv(2'd0, 4'h0, 10'h3ff);
		t_conv(2'd1, 4'h8, 10'h000);
		t_conv(2'd2, 4'h3, 10'h2a5);
		t_conv(2'd3, 4'h5, 10'h15a);
		t_refused_start();
		finish_test();
	end
endmodule : sadc_top_tb

`default_nettype wire
